// >>> hdl/dram_latency_mode_register.sv
`timescale 1ns/1ps
`default_nettype none
`include "lat_mode_defines.svh"

module dram_latency_mode_register #(
    parameter int LAT_W = 8
) (
    input  wire logic                      CLK_SYS_I,      // System clock, 200 MHz.
    input  wire logic                      SYS_RST_I,      // Synchronous reset, active high.
    input  wire logic                      CK_LINK_I,      // Controller command clock.
    input  wire lat_mode_pkg::ca_cmd_t     CMD_I,          // Decoded command, link domain.
    input  wire logic                      WR_SET_POINT_I, // write_set_point_select, link domain.
    input  wire logic                      OP_SET_POINT_I, // operating_set_point_select, link domain.
    input  wire logic                      READ_INV_EN_I,  // read_bus_inversion_enable, link domain.
    input  wire logic                      BURST_32_I,     // Current read uses 32 beats, system domain.
    output logic [7:0]                     MRR_DATA_O,     // Mode read data, link domain.
    output logic                           MRR_VALID_O,    // Mode read data valid pulse, link domain.
    output logic                           LEVELING_O,     // Leveling state, link domain.
    output logic                           CMD_REJECT_O,   // Command refused during leveling, link domain.
    output logic [LAT_W-1:0]               READ_LATENCY_O, // read_latency in command clocks.
    output logic [LAT_W-1:0]               WRITE_LATENCY_O,// write_latency in command clocks.
    output logic [LAT_W-1:0]               READ_TO_PRE_O,  // read_to_precharge_cycles incl. burst extra.
    output logic                           WR_LEVEL_EN_O   // Active copy leveling enable, system domain.
);
    import lat_mode_pkg::*;

    localparam logic [63:0] RD_LAT_PLAIN    = `READ_LAT_TABLE_PLAIN;
    localparam logic [63:0] RD_LAT_INVERTED = `READ_LAT_TABLE_INVERTED;
    localparam logic [63:0] RTP_TBL         = `RTP_TABLE;
    localparam logic [63:0] WR_LAT_SET_A    = `WRITE_LAT_TABLE_SET_A;
    localparam logic [63:0] WR_LAT_SET_B    = `WRITE_LAT_TABLE_SET_B;

    logic        rst_lk_meta_r;
    logic        rst_lk_r;
    llc_cfg_t    copy_r [2];
    logic        lvl_r;
    logic        mrw_hit;
    logic        mrr_hit;
    logic        accept;
    active_cfg_t act;
    active_cfg_t send_r;
    logic        req_r;
    logic        ack_meta_r;
    logic        ack_sync_r;
    logic        pending;
    logic        req_meta_r;
    logic        req_sync_r;
    logic        req_seen_r;
    active_cfg_t cur_r;
    logic [5:0]  rd_idx;
    logic [5:0]  wr_idx;
    logic [7:0]  rd_lat_val;
    logic [7:0]  wr_lat_val;
    logic [7:0]  rtp_val;

    // Reset reaches the link domain through two flip-flops so its release is clean there.
    always_ff @(posedge CK_LINK_I)
    begin
        rst_lk_meta_r <= SYS_RST_I;
        rst_lk_r      <= rst_lk_meta_r;
    end

    // Command decode for this register's address.
    assign mrw_hit = CMD_I.valid && CMD_I.is_mrw && (CMD_I.addr == `LLC_MODE_ADDR);
    assign mrr_hit = CMD_I.valid && CMD_I.is_mrr && (CMD_I.addr == `LLC_MODE_ADDR);
    // While leveling, only a mode write that clears the leveling bit is honoured.
    assign accept  = !lvl_r || (mrw_hit && !CMD_I.op[7]);

    // Mode writes land only in the copy picked by the write set-point select.
    always_ff @(posedge CK_LINK_I)
    begin
        if (rst_lk_r)
        begin
            copy_r[0] <= `LLC_RESET_VALUE;
            copy_r[1] <= `LLC_RESET_VALUE;
        end
        else if (mrw_hit && accept)
        begin
            copy_r[WR_SET_POINT_I] <= CMD_I.op;
        end
    end

    // Leveling state follows the bit of each accepted mode write.
    always_ff @(posedge CK_LINK_I)
    begin
        if (rst_lk_r)
        begin
            lvl_r <= 1'b0;
        end
        else if (mrw_hit && accept)
        begin
            lvl_r <= CMD_I.op[7];
        end
    end

    assign LEVELING_O = lvl_r;

    // Any other command during leveling is dropped and flagged for one link cycle.
    always_ff @(posedge CK_LINK_I)
    begin
        if (rst_lk_r)
        begin
            CMD_REJECT_O <= 1'b0;
        end
        else
        begin
            CMD_REJECT_O <= CMD_I.valid && !accept;
        end
    end

    // Mode reads return the copy picked by the write set-point select.
    always_ff @(posedge CK_LINK_I)
    begin
        if (rst_lk_r)
        begin
            MRR_DATA_O  <= 8'h00;
            MRR_VALID_O <= 1'b0;
        end
        else
        begin
            MRR_VALID_O <= mrr_hit && accept;
            if (mrr_hit && accept)
            begin
                MRR_DATA_O <= copy_r[WR_SET_POINT_I];
            end
        end
    end

    // Only the operating copy ever leaves the link domain, so edits to the other copy stay invisible.
    assign act.cfg                       = copy_r[OP_SET_POINT_I];
    assign act.read_bus_inversion_enable = READ_INV_EN_I;
    assign pending                       = (req_r != ack_sync_r);

    // Toggle handshake: the word is held still until the system side has taken it.
    always_ff @(posedge CK_LINK_I)
    begin
        if (rst_lk_r)
        begin
            send_r     <= {1'b0, `LLC_RESET_VALUE};
            req_r      <= 1'b0;
            ack_meta_r <= 1'b0;
            ack_sync_r <= 1'b0;
        end
        else
        begin
            ack_meta_r <= req_seen_r;
            ack_sync_r <= ack_meta_r;
            if (!pending && (act != send_r))
            begin
                send_r <= act;
                req_r  <= ~req_r;
            end
        end
    end

    // System side: catch the request toggle and take the held word.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
            req_seen_r <= 1'b0;
            cur_r      <= {1'b0, `LLC_RESET_VALUE};
        end
        else
        begin
            req_meta_r <= req_r;
            req_sync_r <= req_meta_r;
            if (req_sync_r != req_seen_r)
            begin
                req_seen_r <= req_sync_r;
                cur_r      <= send_r;
            end
        end
    end

    // Table lookups; each code selects one byte of its table.
    assign rd_idx     = {cur_r.cfg.read_latency_code, 3'h0};
    assign wr_idx     = {cur_r.cfg.write_latency_code, 3'h0};
    assign rd_lat_val = cur_r.read_bus_inversion_enable ? RD_LAT_INVERTED[rd_idx +: 8]
                                                        : RD_LAT_PLAIN[rd_idx +: 8];
    assign wr_lat_val = cur_r.cfg.write_latency_set_select ? WR_LAT_SET_B[wr_idx +: 8]
                                                           : WR_LAT_SET_A[wr_idx +: 8];
    assign rtp_val    = RTP_TBL[rd_idx +: 8];

    // Decoded counts are in command clock cycles, first data beat measured from the command.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (SYS_RST_I)
        begin
            READ_LATENCY_O  <= LAT_W'(RD_LAT_PLAIN[7:0]);
            WRITE_LATENCY_O <= LAT_W'(WR_LAT_SET_A[7:0]);
            READ_TO_PRE_O   <= LAT_W'(RTP_TBL[7:0]);
            WR_LEVEL_EN_O   <= 1'b0;
        end
        else
        begin
            READ_LATENCY_O  <= LAT_W'(rd_lat_val);
            WRITE_LATENCY_O <= LAT_W'(wr_lat_val);
            READ_TO_PRE_O   <= LAT_W'(rtp_val + (BURST_32_I ? `RTP_BURST32_EXTRA : 8'h00));
            WR_LEVEL_EN_O   <= cur_r.cfg.wr_level_en;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/lat_mode_defines.svh
`ifndef LAT_MODE_DEFINES_SVH
`define LAT_MODE_DEFINES_SVH

// Mode-register address of the latency and leveling configuration.
`define LLC_MODE_ADDR     6'h02
// Reset value of both set-point copies: all codes 000, leveling off.
`define LLC_RESET_VALUE   8'h00

// Decode tables, one byte per code, code 000 in the lowest byte.
`define READ_LAT_TABLE_PLAIN    64'h24201C18140E0A06
`define READ_LAT_TABLE_INVERTED 64'h2824201C16100C06
`define RTP_TABLE               64'h100E0C0A08080808
`define WRITE_LAT_TABLE_SET_A   64'h12100E0C0A080604
`define WRITE_LAT_TABLE_SET_B   64'h221E1A16120C0804

// Extra read-to-precharge cycles added for 32-beat bursts.
`define RTP_BURST32_EXTRA 8'h08

`endif

// >>> hdl/lat_mode_pkg.sv
package lat_mode_pkg;

    // Field layout of the latency and leveling configuration byte.
    typedef struct packed {
        logic       wr_level_en;
        logic       write_latency_set_select;
        logic [2:0] write_latency_code;
        logic [2:0] read_latency_code;
    } llc_cfg_t;

    // One command as seen on the command/address bus, already decoded.
    typedef struct packed {
        logic       valid;
        logic       is_mrw;
        logic       is_mrr;
        logic [5:0] addr;
        logic [7:0] op;
    } ca_cmd_t;

    // Word that crosses from the link domain to the system domain.
    typedef struct packed {
        logic     read_bus_inversion_enable;
        llc_cfg_t cfg;
    } active_cfg_t;

endpackage

// >>> verif/lat_mode_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Port checks: command rules on the link clock, decode rules on the system clock.
module lat_mode_asserts #(
    parameter int LAT_W = 8
) (
    input wire logic                  CLK_SYS_I,       // Clock.
    input wire logic                  SYS_RST_I,       // Reset.
    input wire logic                  CK_LINK_I,       // Link clock.
    input wire lat_mode_pkg::ca_cmd_t CMD_I,           // Command.
    input wire logic                  BURST_32_I,      // Burst.
    input wire logic                  MRR_VALID_O,     // Read pulse.
    input wire logic                  LEVELING_O,      // Leveling.
    input wire logic                  CMD_REJECT_O,    // Refusal.
    input wire logic [LAT_W-1:0]      READ_LATENCY_O,  // Read latency.
    input wire logic [LAT_W-1:0]      WRITE_LATENCY_O, // Write latency.
    input wire logic [LAT_W-1:0]      READ_TO_PRE_O    // Precharge delay.
);
    import lat_mode_pkg::*;
    // Commands aimed at this register; only a clearing write may leave leveling.
    wire logic wr_hit = CMD_I.valid && CMD_I.is_mrw && CMD_I.addr == 6'h02;
    wire logic rd_hit = CMD_I.valid && CMD_I.is_mrr && CMD_I.addr == 6'h02;
    wire logic clr_hit = wr_hit && !CMD_I.op[7];
    level_enter_a: assert property (@(posedge CK_LINK_I) disable iff (SYS_RST_I)
        !LEVELING_O && wr_hit && CMD_I.op[7] |=> LEVELING_O) else $error("leveling not entered");
    level_exit_a: assert property (@(posedge CK_LINK_I) disable iff (SYS_RST_I)
        LEVELING_O && clr_hit |=> !LEVELING_O) else $error("leveling not left");
    level_hold_a: assert property (@(posedge CK_LINK_I) disable iff (SYS_RST_I)
        LEVELING_O && !clr_hit |=> LEVELING_O) else $error("leveling dropped early");
    level_refuse_a: assert property (@(posedge CK_LINK_I) disable iff (SYS_RST_I)
        LEVELING_O && CMD_I.valid && !clr_hit |=> CMD_REJECT_O && !MRR_VALID_O) else $error("command not refused");
    read_answer_a: assert property (@(posedge CK_LINK_I) disable iff (SYS_RST_I)
        !LEVELING_O && rd_hit |=> MRR_VALID_O) else $error("mode read not answered");
    read_cause_a: assert property (@(posedge CK_LINK_I) disable iff (SYS_RST_I)
        $rose(MRR_VALID_O) |-> $past(rd_hit)) else $error("read pulse without read");
    burst_extra_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        $rose(BURST_32_I) && $stable(READ_LATENCY_O) |=> READ_TO_PRE_O == $past(READ_TO_PRE_O) + 8'h08)
        else $error("burst extra not added");
    burst_range_a: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
        $past(BURST_32_I) |-> READ_TO_PRE_O >= 8'h10 && READ_TO_PRE_O <= 8'h18 && !WRITE_LATENCY_O[0])
        else $error("precharge delay out of range");
endmodule
bind dram_latency_mode_register lat_mode_asserts #(.LAT_W(LAT_W)) i_chk (.CLK_SYS_I, .SYS_RST_I, .CK_LINK_I,
    .CMD_I, .BURST_32_I, .MRR_VALID_O, .LEVELING_O, .CMD_REJECT_O, .READ_LATENCY_O, .WRITE_LATENCY_O, .READ_TO_PRE_O);
`default_nettype wire

// >>> verif/ca_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side of the command bus: one command every two link cycles, each followed by an idle cycle, aimed at this register.
module ca_ctrl_model (
    input  wire logic                 ck_i,  // Link clock.
    output var lat_mode_pkg::ca_cmd_t cmd_o  // Command to the device.
);
    import lat_mode_pkg::*;
    initial cmd_o = '0;
    // Idle fields are inverted so a stale command never looks live.
    task automatic send(input logic wr, input logic [7:0] op);
        @(posedge ck_i);
        // The bench link clock sits below every frequency band, so codes only exercise the decode here.
        cmd_o <= {1'b1, wr, !wr, 6'h02, op};
        @(posedge ck_i);
        cmd_o <= {1'b0, !wr, wr, 6'h3D, ~op};
        #1;
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_dram_latency_mode_register.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
// Mode writes and reads through the controller model; decoded latencies compared with the tables.
module tb_dram_latency_mode_register;
    import lat_mode_pkg::*;
    logic clk = 1'b0, ck = 1'b0, rst = 1'b1, wsp = 1'b0, osp = 1'b0, inv = 1'b0, brst = 1'b0;
    logic [7:0] mrr_d, rd_lat, wr_lat, rtp;
    logic mrr_v, lev, rej, wle;
    ca_cmd_t cmd;
    int n_errors = 0, checked = 0, cycles = 0;
    logic [7:0] lat_plain [8] = '{8'h06, 8'h0A, 8'h0E, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    logic [7:0] lat_inv [8]   = '{8'h06, 8'h0C, 8'h10, 8'h16, 8'h1C, 8'h20, 8'h24, 8'h28};
    logic [7:0] lat_set_b [8] = '{8'h04, 8'h08, 8'h0C, 8'h12, 8'h16, 8'h1A, 8'h1E, 8'h22};
    // The link clock runs free at 160 ns, unrelated to the 5 ns system clock.
    always #2.5 clk = ~clk;
    always #80 ck = ~ck;
    dram_latency_mode_register i_dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CK_LINK_I(ck), .CMD_I(cmd),
        .WR_SET_POINT_I(wsp), .OP_SET_POINT_I(osp), .READ_INV_EN_I(inv), .BURST_32_I(brst), .MRR_DATA_O(mrr_d),
        .MRR_VALID_O(mrr_v), .LEVELING_O(lev), .CMD_REJECT_O(rej), .READ_LATENCY_O(rd_lat), .WRITE_LATENCY_O(wr_lat),
        .READ_TO_PRE_O(rtp), .WR_LEVEL_EN_O(wle));
    ca_ctrl_model i_ctrl (.ck_i(ck), .cmd_o(cmd));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // A crossing takes at most two link and four system cycles, so four link cycles is ample.
    task automatic settle();
        repeat (4) @(posedge ck);
        #1;
    endtask
    task automatic decode(input logic [2:0] c, input logic b);
        i_ctrl.send(1'b1, {1'b0, b, c, c});
        settle();
        `CHK("read latency", inv ? lat_inv[c] : lat_plain[c], rd_lat)
        `CHK("write latency", b ? lat_set_b[c] : 8'h04 + {c, 1'b0}, wr_lat)
        `CHK("precharge delay", c < 3'h4 ? 8'h08 : 8'h02 + {c, 1'b0}, rtp)
    endtask
    // A hang is cut short well past the roughly 4300 cycles the run needs.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_errors++;
            finish_test();
        end
    end
    // Reset is stretched over three link edges because the link side syncs it.
    initial
    begin
        repeat (12) @(posedge clk);
        repeat (3) @(posedge ck);
        @(posedge clk) rst <= 1'b0;
        settle();
        `CHK("reset read latency", 8'h06, rd_lat)
        `CHK("reset write latency", 8'h04, wr_lat)
        `CHK("reset rtp", 8'h08, rtp)
        `CHK("reset leveling", 1'b0, wle)
        $display("test reset done");
        for (int k = 0; k < 16; k++)
        begin
            if (k == 8)
                @(posedge ck) inv <= 1'b1;
            decode(k[2:0], k[3]);
        end
        @(posedge clk) brst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK("burst rtp", 8'h18, rtp)
        @(posedge clk) brst <= 1'b0;
        $display("test decode done");
        @(posedge ck) wsp <= 1'b1;
        i_ctrl.send(1'b1, 8'h3F);
        i_ctrl.send(1'b0, 8'h00);
        `CHK("read copy one", 9'h13F, {mrr_v, mrr_d})
        settle();
        `CHK("inactive write", 8'h22, wr_lat)
        @(posedge ck) wsp <= 1'b0;
        i_ctrl.send(1'b0, 8'h00);
        `CHK("read copy zero", 9'h17F, {mrr_v, mrr_d})
        @(posedge ck) osp <= 1'b1;
        settle();
        `CHK("active switch", 16'h2812, {rd_lat, wr_lat})
        $display("test set point done");
        @(posedge ck) wsp <= 1'b1;
        i_ctrl.send(1'b1, 8'hBF);
        `CHK("leveling on", 1'b1, lev)
        i_ctrl.send(1'b0, 8'h00);
        `CHK("refused read", 2'b10, {rej, mrr_v})
        settle();
        `CHK("leveling bit", 1'b1, wle)
        i_ctrl.send(1'b1, 8'h3F);
        `CHK("leveling off", 1'b0, lev)
        settle();
        `CHK("leveling bit off", 1'b0, wle)
        $display("test leveling done");
        finish_test();
    end
endmodule
`default_nettype wire
